// ### verilog/rt16_timer.sv
// file: one 16-bit reload timer channel
`timescale 1ns/1ps
module rt16_timer
  import rt16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire rt16_ctrl_t ctrl,
  input wire logic timer_in,
  output rt16_stat_t stat
);
  rt16_state_t s_q;
  rt16_state_t s_d;
  logic tick;
  logic edge_seen;
  logic match;

  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + 16'h0001;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.out_pulse = 1'b0;
    s_d.in_s1 = timer_in;
    s_d.in_s2 = s_q.in_s1;
    s_d.in_s3 = s_q.in_s2;
    // edge logic looks only at second and third stages
    edge_seen = ctrl.output_polarity_edge_select ? (s_q.in_s2 & ~s_q.in_s3)
                                                 : (~s_q.in_s2 & s_q.in_s3);
    tick = 1'b0;
    match = 1'b0;
    if (!s_q.enabled) begin
      s_d.pre = RT16_PRE_RST;
      // level latched only while idle, so a polarity flip while running shows only once the timer stops
      s_d.out_level = ctrl.output_polarity_edge_select;
    end else if (ctrl.mode == RT16_COUNTER) begin
      tick = edge_seen;
    end else if (s_q.pre >= ctrl.prescale_m1) begin
      s_d.pre = RT16_PRE_RST;
      tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + 7'h01;
    end
    if (tick) begin
      if (s_q.count == ctrl.reload) begin
        match = 1'b1;
        s_d.count = RT16_RESTART;
        s_d.irq = 1'b1;
        case (ctrl.mode)
          RT16_ONE_SHOT: begin
            s_d.enabled = 1'b0;
            s_d.out_pulse = ctrl.output_enable;
          end
          default: begin
            if (ctrl.output_enable) begin
              s_d.out_level = ~s_q.out_level;
            end
          end
        endcase
      end else begin
        s_d.count = inc16(s_q.count);
      end
    end
    if (ctrl.count_wr) begin
      s_d.count = ctrl.count_wdata;
    end
    if (ctrl.enable_clr) begin
      s_d.enabled = 1'b0;
    end else if (ctrl.enable_set && !match) begin
      s_d.enabled = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.count <= RT16_CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat.enabled = s_q.enabled;
  assign stat.count = s_q.count;
  assign stat.irq = s_q.irq;
  assign stat.timer_out = s_q.out_level ^ s_q.out_pulse;

  property p_oneshot_stop;
    @(posedge ref_clk) disable iff (rst)
      (s_q.irq && ctrl.mode == RT16_ONE_SHOT && !$past(ctrl.enable_set)
       && !$past(ctrl.count_wr))
      |-> (!s_q.enabled && s_q.count == RT16_RESTART);
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

  property p_pulse_one;
    @(posedge ref_clk) disable iff (rst)
      s_q.out_pulse |=> !s_q.out_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("output pulse too long");

  property p_cont_run;
    @(posedge ref_clk) disable iff (rst)
      (s_q.irq && ctrl.mode == RT16_CONTINUOUS && !$past(ctrl.enable_clr)
       && !$past(ctrl.count_wr))
      |-> (s_q.enabled && s_q.count == RT16_RESTART);
  endproperty
  a_cont_run: assert property (p_cont_run) else $error("continuous mode stopped");

  property p_toggle;
    @(posedge ref_clk) disable iff (rst)
      (s_q.irq && ctrl.mode != RT16_ONE_SHOT && $past(ctrl.output_enable)
       && $stable(ctrl.mode)) |-> (s_q.out_level != $past(s_q.out_level));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_wrap;
    @(posedge ref_clk) disable iff (rst)
      (tick && !match && !ctrl.count_wr && s_q.count == 16'hFFFF) |=> s_q.count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");

  property p_pre_period;
    @(posedge ref_clk) disable iff (rst)
      (s_q.enabled && ctrl.mode != RT16_COUNTER && ctrl.prescale_m1 == 7'h01 && tick)
      |=> (!tick || !s_q.enabled);
  endproperty
  a_pre_period: assert property (p_pre_period) else $error("prescale two ticked twice");

  property p_pre_restart;
    @(posedge ref_clk) disable iff (rst)
      !s_q.enabled |=> (s_q.pre == RT16_PRE_RST);
  endproperty
  a_pre_restart: assert property (p_pre_restart) else $error("prescaler not restarted");

  property p_cnt_edge;
    @(posedge ref_clk) disable iff (rst)
      (s_q.enabled && ctrl.mode == RT16_COUNTER && !edge_seen && !ctrl.count_wr)
      |=> $stable(s_q.count);
  endproperty
  a_cnt_edge: assert property (p_cnt_edge) else $error("count without input edge");

  property p_cnt_level;
    @(posedge ref_clk) disable iff (rst)
      (!s_q.enabled && ctrl.mode == RT16_COUNTER && $stable(ctrl.mode))
      |=> s_q.out_level == $past(ctrl.output_polarity_edge_select);
  endproperty
  a_cnt_level: assert property (p_cnt_level) else $error("initial level wrong");

  property p_oneshot_hold;
    @(posedge ref_clk) disable iff (rst)
      (s_q.enabled && ctrl.mode == RT16_ONE_SHOT) |=> $stable(s_q.out_level);
  endproperty
  a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot level moved");

  property p_cnt_resume;
    @(posedge ref_clk) disable iff (rst)
      (s_q.irq && ctrl.mode == RT16_COUNTER && !$past(ctrl.enable_clr)
       && !$past(ctrl.count_wr))
      |-> (s_q.enabled && s_q.count == RT16_RESTART);
  endproperty
  a_cnt_resume: assert property (p_cnt_resume) else $error("counter mode stopped");
endmodule // rt16_timer

// ### verilog/rt16_pkg.sv
// package: constants and types for the dual 16-bit reload timer
// Operation
// - two independent timers, each a 16-bit reloadable counter
// - counters count up; FFFFh wraps to 0000h and counting continues
// - prescaler divides system clock by 1 to 128 in clock-driven modes
// - reload 0001h with prescale one gives the shortest time-out
// - reload 0000h with prescale 128 gives longest time-out through the wrap
// - one-shot and continuous modes count prescaled system clock only
// - one-shot match: interrupt, count to 0001h, enable clears, counting stops
// - one-shot output inverts for exactly one clock at reload if enabled
// - continuous match: interrupt, count to 0001h, keeps counting
// - continuous and counter modes toggle output on every reload
// - written start count applies to first pass only; later passes start 0001h
// - counter mode counts input pin transitions, prescaler bypassed
// - counter mode polarity selects rising or falling input edges
// - counter mode polarity sets initial output level regardless of output enable
// - counter mode match: interrupt, count to 0001h, resume counting edges
package rt16_pkg;
  localparam int RT16_W = 16;
  localparam int RT16_NUM = 2;
  localparam int RT16_PRE_W = 7;
  localparam logic [15:0] RT16_RESTART = 16'h0001;
  localparam logic [15:0] RT16_CNT_RST = 16'h0000;
  localparam logic [15:0] RT16_RLD_RST = 16'h0000;
  localparam logic [6:0] RT16_PRE_RST = 7'h00;

  typedef enum logic [1:0] {
    RT16_ONE_SHOT = 2'h0,
    RT16_CONTINUOUS = 2'h1,
    RT16_COUNTER = 2'h3
  } rt16_mode_t;

  // software control of one timer; prescale field holds divisor minus one
  typedef struct packed {
    logic enable_set;
    logic enable_clr;
    rt16_mode_t mode;
    logic [6:0] prescale_m1;
    logic output_polarity_edge_select;
    logic output_enable;
    logic count_wr;
    logic [15:0] count_wdata;
    logic [15:0] reload;
  } rt16_ctrl_t;

  typedef struct packed {
    logic enabled;
    logic [15:0] count;
    logic irq;
    logic timer_out;
  } rt16_stat_t;

  typedef struct packed {
    logic enabled;
    logic [15:0] count;
    logic [6:0] pre;
    logic irq;
    logic out_level;
    logic out_pulse;
    logic in_s1;
    logic in_s2;
    logic in_s3;
  } rt16_state_t;
endpackage

// ### verilog/rt16_top.sv
// file: dual 16-bit reload timer top with registered outputs
`timescale 1ns/1ps
module rt16_top
  import rt16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire rt16_ctrl_t ctrl0,
  input wire rt16_ctrl_t ctrl1,
  input wire logic timer_in0,
  input wire logic timer_in1,
  output rt16_stat_t stat0_q,
  output rt16_stat_t stat1_q
);
  rt16_stat_t st0;
  rt16_stat_t st1;

  // two independent channels
  rt16_timer u_t0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ctrl(ctrl0),
    .timer_in(timer_in0),
    .stat(st0)
  );

  rt16_timer u_t1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ctrl(ctrl1),
    .timer_in(timer_in1),
    .stat(st1)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat0_q <= '0;
      stat1_q <= '0;
    end else begin
      stat0_q <= st0;
      stat1_q <= st1;
    end
  end
endmodule // rt16_top

// ### tb/rt16_pin_src.sv
// external timer input source driving a slow square wave
`timescale 1ns/1ps
module rt16_pin_src (
  input wire logic ref_clk,
  input wire logic run,
  output logic timer_in
);
  logic [1:0] ph = 2'h0;
  initial timer_in = 1'b0;
  // four clocks per phase, one eighth of the clock rate
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    if (run && ph == 2'h3) timer_in <= ~timer_in;
  end
endmodule // rt16_pin_src

// ### tb/reload_timer_16bit_tb.sv
// bench for the dual reload timer
`timescale 1ns/1ps
module reload_timer_16bit_tb;
  import rt16_pkg::*;
  logic ref_clk;
  logic rst;
  logic run;
  logic pin;
  rt16_ctrl_t c[2];
  rt16_stat_t s[2];
  int q[2][$];
  int gap[2] = '{0, 0};
  logic op[2];
  int n;
  int pm;
  int rl;
  int err_count = 0;
  int compares = 0;
  rt16_top uut (.ref_clk(ref_clk), .rst(rst), .ctrl0(c[0]), .ctrl1(c[1]), .timer_in0(pin),
    .timer_in1(pin), .stat0_q(s[0]), .stat1_q(s[1]));
  rt16_pin_src src (.ref_clk(ref_clk), .run(run), .timer_in(pin));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // each reload pulse takes the oldest expected spacing; zero means first pass
  always @(posedge ref_clk) begin
    #1;
    for (int i = 0; i < 2; i++) begin
      gap[i]++;
      if (s[i].irq === 1'b1) begin
        n = (q[i].size() > 0) ? q[i].pop_front() : -1;
        chk(n == 0 || gap[i] == n, "reload spacing");
        chk(s[i].count === RT16_RESTART, "count after reload");
        chk(s[i].enabled === (c[i].mode != RT16_ONE_SHOT), "enable after reload");
        chk(s[i].timer_out !== op[i], "output at reload");
        gap[i] = 0;
      end
      op[i] = s[i].timer_out;
    end
  end
  task automatic cfg(input int i, input rt16_mode_t m, input int p, input int r, input int st,
      input logic pol);
    rt16_ctrl_t k;
    // disable alone first so the old setup cannot meet the new reload value
    k = c[i];
    k.enable_set = 1'b0;
    k.enable_clr = 1'b1;
    k.count_wr = 1'b0;
    @(posedge ref_clk);
    c[i] <= k;
    k = '{1'b0, 1'b1, m, p[6:0], pol, 1'b1, 1'b1, st[15:0], r[15:0]};
    @(posedge ref_clk);
    c[i] <= k;
    repeat (3) @(posedge ref_clk);
    #1;
    if (m == RT16_COUNTER) chk(s[i].timer_out === pol, "idle output level");
    k.enable_clr = 1'b0;
    k.count_wr = 1'b0;
    k.enable_set = 1'b1;
    @(posedge ref_clk);
    c[i] <= k;
    k.enable_set = 1'b0;
    @(posedge ref_clk);
    c[i] <= k;
  endtask
  task automatic drain(input int i);
    int k;
    k = 0;
    while (q[i].size() != 0 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    if (q[i].size() != 0) begin
      chk(1'b0, "no reload seen");
      conclude();
    end
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    c[0] = '0;
    c[1] = '0;
    void'($urandom(32'h2E2FA0BE));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    run <= 1'b1;
    // input pin toggles throughout; clock-driven modes must ignore it
    for (int t = 0; t < 3; t++) begin
      pm = $urandom_range(3, 0);
      rl = $urandom_range(9, 6);
      q[0] = '{0, (pm + 1) * rl, (pm + 1) * rl};
      cfg(0, RT16_CONTINUOUS, pm, rl, rl - 1, 1'b0);
      drain(0);
    end
    $display("test continuous done");
    // shortest time-out, then a pass through the wrap to reload 0000h
    for (int t = 0; t < 2; t++) begin
      q[0] = '{0};
      cfg(0, RT16_ONE_SHOT, 0, 1 - t, t * 16'hFFF0, t[0]);
      drain(0);
      repeat (20) @(posedge ref_clk);
      #1;
      chk(s[0].enabled === 1'b0 && s[0].count === RT16_RESTART, "one-shot stop");
      chk(s[0].timer_out === t[0], "one-shot pulse end");
    end
    // polarity flipped after start: output keeps its level until reload, then stays changed
    q[0] = '{0};
    cfg(0, RT16_ONE_SHOT, 0, 40, 1, 1'b0);
    @(posedge ref_clk);
    c[0].output_polarity_edge_select <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(s[0].timer_out === 1'b0, "level held while running");
    drain(0);
    repeat (20) @(posedge ref_clk);
    #1;
    chk(s[0].timer_out === 1'b1, "lasting level after reload");
    $display("test one-shot done");
    // rising then falling edges, three edges of eight clocks per pass; prescale must not apply
    for (int t = 1; t >= 0; t--) begin
      q[1] = '{0, 24, 24};
      cfg(1, RT16_COUNTER, 127, 3, 1, t[0]);
      drain(1);
    end
    $display("test counter done");
    conclude();
  end
endmodule // reload_timer_16bit_tb
